// ===== rtl/ddib_core.sv
`timescale 1ns/1ns
// Notes on behaviour
// - One divide step: b gets quotient of a by r, a keeps twice remainder.
// - N chained steps give quotient times 2^(N-1), remainder times 2^N.
// - Initialize resets capacitance converter, resistance converter and core.
// - Initialize copies stored nonvolatile configuration into active configuration registers.
// - Branch on carry clear loads target when carry is 0; flags untouched.
// - The conditional branch never pushes a return address on the stack.
// - Branch target is PC relative, reach -128 to +127 bytes.
module ddib_core import ddib_pkg::*; #(
  parameter int CFG_WORDS = 16
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire ddib_instr_t I_INSTR,
  input wire ddib_wb_t I_WB,
  input wire logic [DDIB_DW-1:0] I_NV_DATA,
  output logic O_READY,
  output logic [DDIB_PCW-1:0] O_PC,
  output logic [DDIB_DW-1:0] O_ACC_A,
  output logic [DDIB_DW-1:0] O_ACC_B,
  output logic [DDIB_DW-1:0] O_ACC_R,
  output ddib_flags_t O_FLAGS,
  output logic O_CAP_CONV_RST,
  output logic O_RESISTANCE_CONVERTER_RST,
  output logic O_CORE_RST,
  output logic O_NV_RD,
  output logic [DDIB_CFG_AW-1:0] O_NV_ADDR,
  output ddib_cfg_wr_t O_CFG_WR
);

  localparam logic [DDIB_CFG_AW-1:0] LAST_ADDR = DDIB_CFG_AW'(CFG_WORDS - 1);

  ddib_state_t state, next_state;
  logic [DDIB_PCW-1:0] pc, next_pc;
  logic [DDIB_DW-1:0] acc_a, next_acc_a;
  logic [DDIB_DW-1:0] acc_b, next_acc_b;
  logic [DDIB_DW-1:0] acc_r, next_acc_r;
  ddib_flags_t flags, next_flags;
  logic [DDIB_CFG_AW-1:0] cfg_addr, next_cfg_addr;
  logic rst_pulse, next_rst_pulse;
  ddib_cfg_wr_t cfg_wr, next_cfg_wr;

  // Opcode match for an instruction offered while the slice accepts work
  function automatic logic take_op(input ddib_instr_t instr, input ddib_state_t st,
    input logic [7:0] code);
    return instr.valid && (st == DDIB_ST_RUN) && (instr.opcode == code);
  endfunction

  // Write-back hit on one accumulator
  function automatic logic wb_hit(input ddib_wb_t wb, input logic [1:0] sel);
    return wb.acc_we && (wb.acc_sel == sel);
  endfunction

  // Instruction kinds, only while the slice accepts instructions
  logic run, do_div, do_init, do_jcc;
  assign run = I_INSTR.valid && (state == DDIB_ST_RUN);
  assign do_div = take_op(I_INSTR, state, DDIB_OP_DIV);
  assign do_init = take_op(I_INSTR, state, DDIB_OP_INIT);
  assign do_jcc = take_op(I_INSTR, state, DDIB_OP_JCC);

  // Divide step: one restoring quotient bit per instruction
  logic [DDIB_DW:0] div_diff;
  logic div_q;
  logic [DDIB_DW-1:0] div_rem;
  logic [DDIB_DW-1:0] div_quot;
  assign div_diff = {1'b0, acc_a} - {1'b0, acc_r};
  assign div_q = ~div_diff[DDIB_DW];
  assign div_rem = div_q ? div_diff[DDIB_DW-1:0] : acc_a;
  assign div_quot = {acc_b[DDIB_DW-2:0], div_q};

  // Relative branch target from the signed byte operand
  logic [DDIB_PCW-1:0] jcc_ofs;
  assign jcc_ofs = {{(DDIB_PCW-DDIB_OFS_MSB-1){I_INSTR.operand[DDIB_OFS_MSB]}},
    I_INSTR.operand};

  // Next accumulator values: divide and initialize win over a write-back
  always_comb begin
    next_acc_a = acc_a;
    next_acc_b = acc_b;
    next_acc_r = acc_r;
    // Write-back from the rest of the core, only while running
    if (state == DDIB_ST_RUN) begin
      if (wb_hit(I_WB, DDIB_SEL_A)) begin
        next_acc_a = I_WB.acc_data;
      end
      if (wb_hit(I_WB, DDIB_SEL_B)) begin
        next_acc_b = I_WB.acc_data;
      end
      if (wb_hit(I_WB, DDIB_SEL_R)) begin
        next_acc_r = I_WB.acc_data;
      end
    end
    if (do_div) begin
      // Shifted remainder into a, one more quotient bit into b
      next_acc_a = {div_rem[DDIB_DW-2:0], 1'b0};
      next_acc_b = div_quot;
    end else if (do_init) begin
      next_acc_a = DDIB_ACC_RST;
      next_acc_b = DDIB_ACC_RST;
      next_acc_r = DDIB_ACC_RST;
    end
  end

  // Accumulator registers
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      acc_a <= DDIB_ACC_RST;
      acc_b <= DDIB_ACC_RST;
      acc_r <= DDIB_ACC_RST;
    end else begin
      acc_a <= next_acc_a;
      acc_b <= next_acc_b;
      acc_r <= next_acc_r;
    end
  end

  // Next program counter, flags and converter reset pulse
  always_comb begin
    next_pc = pc;
    next_flags = flags;
    next_rst_pulse = 1'b0;
    // Carry write-back from the rest of the core
    if ((state == DDIB_ST_RUN) && I_WB.carry_we) begin
      next_flags.carry = I_WB.carry_val;
    end
    if (do_div) begin
      // Sign and zero follow the new quotient, carry and overflow hold
      next_flags.sign = div_quot[DDIB_MSB];
      next_flags.zero = (div_quot == DDIB_ACC_RST);
      next_pc = pc + DDIB_LEN_ONE;
    end else if (do_jcc) begin
      // Taken or not, no return address is stored and flags hold
      if (!flags.carry) begin
        next_pc = pc + jcc_ofs;
      end else begin
        next_pc = pc + DDIB_LEN_JCC;
      end
    end else if (do_init) begin
      // Whole core back to start, converters pulsed once
      next_pc = DDIB_PC_RST;
      next_flags = '0;
      next_rst_pulse = 1'b1;
    end else if (run) begin
      next_pc = pc + DDIB_LEN_ONE;
    end
  end

  // Program counter, flag and pulse registers
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      pc <= DDIB_PC_RST;
      flags <= '0;
      rst_pulse <= 1'b0;
    end else begin
      pc <= next_pc;
      flags <= next_flags;
      rst_pulse <= next_rst_pulse;
    end
  end

  // Next values of the configuration copy engine
  always_comb begin
    next_state = state;
    next_cfg_addr = cfg_addr;
    next_cfg_wr = '0;
    case (state)
      DDIB_ST_RUN: begin
        if (do_init) begin
          // Start the reload at the first stored word
          next_cfg_addr = DDIB_CFG_ADDR_RST;
          next_state = DDIB_ST_RD;
        end
      end
      DDIB_ST_RD: begin
        // Read request issued this cycle, data arrives next cycle
        next_state = DDIB_ST_WR;
      end
      DDIB_ST_WR: begin
        // Write the word that the read of the previous cycle returned
        next_cfg_wr.we = 1'b1;
        next_cfg_wr.addr = cfg_addr;
        next_cfg_wr.data = I_NV_DATA;
        if (cfg_addr == LAST_ADDR) begin
          next_state = DDIB_ST_RUN;
        end else begin
          next_cfg_addr = cfg_addr + 1'b1;
          next_state = DDIB_ST_RD;
        end
      end
      default: next_state = DDIB_ST_RUN;
    endcase
  end

  // Copy engine registers
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      state <= DDIB_ST_RUN;
      cfg_addr <= DDIB_CFG_ADDR_RST;
      cfg_wr <= '0;
    end else begin
      state <= next_state;
      cfg_addr <= next_cfg_addr;
      cfg_wr <= next_cfg_wr;
    end
  end

  // Outputs
  assign O_READY = (state == DDIB_ST_RUN);
  assign O_PC = pc;
  assign O_ACC_A = acc_a;
  assign O_ACC_B = acc_b;
  assign O_ACC_R = acc_r;
  assign O_FLAGS = flags;
  assign O_CAP_CONV_RST = rst_pulse;
  assign O_RESISTANCE_CONVERTER_RST = rst_pulse;
  assign O_CORE_RST = rst_pulse;
  assign O_NV_RD = (state == DDIB_ST_RD);
  assign O_NV_ADDR = cfg_addr;
  assign O_CFG_WR = cfg_wr;

endmodule

// ===== rtl/ddib_pkg.sv
package ddib_pkg;
  // Data path and program counter widths
  localparam int DDIB_DW = 32;
  localparam int DDIB_PCW = 12;
  localparam int DDIB_CFG_AW = 8;

  // Instruction codes decoded by this slice
  localparam logic [7:0] DDIB_OP_DIV = 8'h5c;
  localparam logic [7:0] DDIB_OP_INIT = 8'h01;
  localparam logic [7:0] DDIB_OP_JCC = 8'h74;

  // Instruction lengths in bytes
  localparam logic [DDIB_PCW-1:0] DDIB_LEN_ONE = 12'h001;
  localparam logic [DDIB_PCW-1:0] DDIB_LEN_JCC = 12'h002;

  // Reset values
  localparam logic [DDIB_PCW-1:0] DDIB_PC_RST = 12'h000;
  localparam logic [DDIB_DW-1:0] DDIB_ACC_RST = 32'h0000_0000;
  localparam logic [DDIB_CFG_AW-1:0] DDIB_CFG_ADDR_RST = 8'h00;

  // Sign bit of the accumulators and of the branch offset
  localparam int DDIB_MSB = DDIB_DW - 1;
  localparam int DDIB_OFS_MSB = 7;

  // Accumulator selectors for the write-back port
  localparam logic [1:0] DDIB_SEL_A = 2'h0;
  localparam logic [1:0] DDIB_SEL_B = 2'h1;
  localparam logic [1:0] DDIB_SEL_R = 2'h2;

  // Instruction offered to the slice
  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [7:0] operand;
  } ddib_instr_t;

  // Write-back from the rest of the core
  typedef struct packed {
    logic acc_we;
    logic [1:0] acc_sel;
    logic [DDIB_DW-1:0] acc_data;
    logic carry_we;
    logic carry_val;
  } ddib_wb_t;

  // Status flags
  typedef struct packed {
    logic carry;
    logic overflow;
    logic sign;
    logic zero;
  } ddib_flags_t;

  // Configuration copy traffic
  typedef struct packed {
    logic we;
    logic [DDIB_CFG_AW-1:0] addr;
    logic [DDIB_DW-1:0] data;
  } ddib_cfg_wr_t;

  typedef enum logic [1:0] {
    DDIB_ST_RUN = 2'b00,
    DDIB_ST_RD = 2'b01,
    DDIB_ST_WR = 2'b10
  } ddib_state_t;
endpackage

// ===== bench/ddib_assertions.sv
`timescale 1ns/1ns
module ddib_assertions import ddib_pkg::*; (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire ddib_instr_t I_INSTR,
  input wire ddib_wb_t I_WB,
  input wire logic O_READY,
  input wire logic [DDIB_PCW-1:0] O_PC,
  input wire logic [DDIB_DW-1:0] O_ACC_A,
  input wire logic [DDIB_DW-1:0] O_ACC_B,
  input wire logic [DDIB_DW-1:0] O_ACC_R,
  input wire ddib_flags_t O_FLAGS,
  input wire logic O_CAP_CONV_RST,
  input wire logic O_RESISTANCE_CONVERTER_RST,
  input wire logic O_CORE_RST,
  input wire logic O_NV_RD,
  input wire logic [DDIB_CFG_AW-1:0] O_NV_ADDR,
  input wire ddib_cfg_wr_t O_CFG_WR
);
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);
  // Instruction taken at this edge, per opcode
  wire logic dv = I_INSTR.valid && O_READY && I_INSTR.opcode == DDIB_OP_DIV;
  wire logic jc = I_INSTR.valid && O_READY && I_INSTR.opcode == DDIB_OP_JCC;
  wire logic it = I_INSTR.valid && O_READY && I_INSTR.opcode == DDIB_OP_INIT;
  // Steps of the initialize and copy behaviour
  sequence s_clr;
    O_CAP_CONV_RST && O_RESISTANCE_CONVERTER_RST && O_CORE_RST && O_PC == DDIB_PC_RST
    && O_ACC_A == DDIB_ACC_RST && O_ACC_B == DDIB_ACC_RST && O_ACC_R == DDIB_ACC_RST
    && O_FLAGS == '0;
  endsequence
  sequence s_wr;
    !O_NV_RD ##1 O_CFG_WR.we && O_CFG_WR.addr == $past(O_NV_ADDR, 2);
  endsequence
  property p_div_b;
    dv |=> O_ACC_B == {$past(O_ACC_B[30:0]), $past(O_ACC_A >= O_ACC_R)};
  endproperty
  a_div_b: assert property (p_div_b) else $error("quotient bit wrong");
  property p_div_a;
    dv |=> O_ACC_A == ($past(O_ACC_A) - ($past(O_ACC_A >= O_ACC_R) ? $past(O_ACC_R) : '0)) << 1;
  endproperty
  a_div_a: assert property (p_div_a) else $error("remainder wrong");
  property p_div_sz;
    dv |=> O_FLAGS.sign == O_ACC_B[DDIB_MSB] && O_FLAGS.zero == (O_ACC_B == DDIB_ACC_RST);
  endproperty
  a_div_sz: assert property (p_div_sz) else $error("divide flags wrong");
  property p_jt;
    jc && !O_FLAGS.carry |=> O_PC == $past(O_PC) + {{4{$past(I_INSTR.operand[7])}},
      $past(I_INSTR.operand)};
  endproperty
  a_jt: assert property (p_jt) else $error("taken target wrong");
  property p_jn;
    jc && O_FLAGS.carry |=> O_PC == $past(O_PC) + DDIB_LEN_JCC;
  endproperty
  a_jn: assert property (p_jn) else $error("fall through wrong");
  property p_jf;
    jc && !I_WB.carry_we |=> $stable(O_FLAGS);
  endproperty
  a_jf: assert property (p_jf) else $error("flags changed");
  property p_init;
    it |=> s_clr ##1 !O_CORE_RST;
  endproperty
  a_init: assert property (p_init) else $error("init reset wrong");
  property p_rd;
    it |=> O_NV_RD && O_NV_ADDR == DDIB_CFG_ADDR_RST && !O_READY;
  endproperty
  a_rd: assert property (p_rd) else $error("copy start wrong");
  property p_copy;
    O_NV_RD |=> s_wr;
  endproperty
  a_copy: assert property (p_copy) else $error("copy write wrong");
endmodule
bind ddib_core ddib_assertions ddib_assertions_inst (.I_CLK(I_CLK), .I_RST(I_RST),
  .I_INSTR(I_INSTR), .I_WB(I_WB), .O_READY(O_READY), .O_PC(O_PC), .O_ACC_A(O_ACC_A),
  .O_ACC_B(O_ACC_B), .O_ACC_R(O_ACC_R), .O_FLAGS(O_FLAGS), .O_CAP_CONV_RST(O_CAP_CONV_RST),
  .O_RESISTANCE_CONVERTER_RST(O_RESISTANCE_CONVERTER_RST), .O_CORE_RST(O_CORE_RST),
  .O_NV_RD(O_NV_RD), .O_NV_ADDR(O_NV_ADDR), .O_CFG_WR(O_CFG_WR));

// ===== bench/testbench.sv
`timescale 1ns/1ns
module testbench import ddib_pkg::*;;
  logic I_CLK = 0;
  logic I_RST = 1;
  ddib_instr_t I_INSTR = '0;
  ddib_wb_t I_WB = '0;
  logic [31:0] I_NV_DATA = '0;
  logic [31:0] x = 32'h347c;
  logic O_READY;
  logic [11:0] O_PC;
  logic [31:0] O_ACC_A;
  logic [31:0] O_ACC_B;
  ddib_cfg_wr_t O_CFG_WR;
  logic [11:0] ep = '0;
  logic [31:0] ea = '0;
  logic [31:0] eb = '0;
  logic [7:0] d;
  logic tk = 0;
  logic [75:0] q[$];
  int n_fail = 0;
  int checks = 0;
  localparam int NCFG = 2;
  int ncfg = 0;
  // Clock
  always #5 I_CLK = ~I_CLK;
  ddib_core #(.CFG_WORDS(NCFG)) ddib_core_inst (.I_CLK, .I_RST, .I_INSTR, .I_WB, .I_NV_DATA,
    .O_READY, .O_PC, .O_ACC_A, .O_ACC_B, .O_ACC_R(), .O_FLAGS(), .O_CAP_CONV_RST(),
    .O_RESISTANCE_CONVERTER_RST(), .O_CORE_RST(), .O_NV_RD(), .O_NV_ADDR(), .O_CFG_WR);
  function logic [31:0] xs();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  task chk(string s, logic [75:0] e, logic [75:0] v);
    checks++;
    if (e !== v) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", s, e, v);
    end
  endtask
  task complete_run();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Preload write, held until the next edge takes it
  task wb(logic [1:0] s, logic [31:0] v, logic c);
    I_WB <= '{1'b1, s, v, 1'b1, c};
    @(posedge I_CLK);
  endtask
  task idle();
    I_WB <= '0;
    I_INSTR.valid <= 1'b0;
    @(posedge I_CLK);
  endtask
  // Offer one instruction until taken, noting the expected pc, a and b
  task op(logic [7:0] c, logic [7:0] o, logic [11:0] p, logic [31:0] a, logic [31:0] b);
    q.push_back({p, a, b});
    I_INSTR <= '{1'b1, c, o};
    @(negedge I_CLK);
    while (O_READY !== 1'b1) @(negedge I_CLK);
    @(posedge I_CLK);
  endtask
  // Watcher: compare one cycle after each taken instruction
  always @(negedge I_CLK) begin
    if (tk) chk("pc_a_b", q.pop_front(), {O_PC, O_ACC_A, O_ACC_B});
    if (O_CFG_WR.we === 1'b1) begin
      chk("cfg", {ncfg[7:0], I_NV_DATA}, {O_CFG_WR.addr, O_CFG_WR.data});
      ncfg++;
    end
    tk = I_INSTR.valid && O_READY;
  end
  initial begin
    longint n;
    logic [31:0] r;
    logic [31:0] a0;
    repeat (2) @(posedge I_CLK);
    I_RST <= 1'b0;
    repeat (3) begin
      r = (xs() & 32'h0fff_ffff) | 32'h1;
      a0 = xs() % (2 * r - 1) + 1;
      wb(DDIB_SEL_A, a0, 1'b0);
      wb(DDIB_SEL_B, 32'h0, 1'b0);
      wb(DDIB_SEL_R, r, 1'b0);
      idle();
      for (int k = 1; k <= 8; k++) begin
        n = longint'(a0) << (k - 1);
        ep = ep + 1;
        ea = 32'(n % r << 1);
        eb = 32'(n / r);
        op(DDIB_OP_DIV, xs(), ep, ea, eb);
      end
      idle();
    end
    for (int i = 0; i < 4; i++) begin
      d = i[1] ? 8'h7f : 8'h80;
      wb(2'h3, 32'h0, i[0]);
      idle();
      ep = i[0] ? ep + DDIB_LEN_JCC : ep + {{4{d[7]}}, d};
      op(DDIB_OP_JCC, d, ep, ea, eb);
      ep = ep + 1;
      op(8'h00, xs(), ep, ea, eb);
      idle();
    end
    I_NV_DATA <= xs();
    op(DDIB_OP_INIT, 8'h00, 12'h0, 32'h0, 32'h0);
    op(8'h00, 8'h00, 12'h1, 32'h0, 32'h0);
    idle();
    chk("cfg_count", NCFG, ncfg);
    chk("queue", 0, q.size());
    complete_run();
  end
  // Watchdog
  initial begin
    #100000;
    n_fail++;
    complete_run();
  end
endmodule
